// file: design/qed_decoder.sv
// per-axis encoder decoder: quadrature, pulse/direction and stepper output
`timescale 1ns/10ps
// What this block does
// - the two phase inputs are decoded into quadrature states giving four counts per cycle.
// - counting stays correct up to 12,000,000 counts per second and the encoder keeps below it.
// - single-ended or differential phase pairs decode to the same count behaviour.
// - an optional index channel acts as a synchronisation reference for the count in the two quadrature modes.
// - in pulse/direction mode each pulse counts one step in the given direction.
// - in stepper mode no encoder is used and step and direction are driven out.
module qed_decoder (
    // clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         reset,
    // configuration, same clock domain
    input  wire qed_pkg::qed_mode_t           mode,
    input  wire logic                         index_enable,
    input  wire logic                         index_clear,
    // encoder pins, asynchronous
    input  wire qed_pkg::qed_enc_pins_t       enc_pins,
    // stepper command from motion logic, same clock domain
    input  wire logic                         step_request,
    input  wire logic                         step_dir,
    // results
    output logic [qed_pkg::QED_POS_W-1:0]     position,
    output logic [qed_pkg::QED_POS_W-1:0]     index_position,
    output logic                              index_seen,
    output logic                              quad_error,
    output qed_pkg::qed_step_t                step_cmd,
    output logic                              step_busy
);
    import qed_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // synchronise every pin before use
    qed_enc_pins_t pins_s;

    qed_sync #(.WIDTH($bits(qed_enc_pins_t))) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (enc_pins),
        .sync_out (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // phase recovery
    logic phase_a;
    logic phase_b;
    logic diff_a_ok;
    logic diff_b_ok;

    // a differential pair is trusted only while its halves disagree
    assign diff_a_ok = pins_s.phase_a_input ^ pins_s.phase_a_complement;
    assign diff_b_ok = pins_s.phase_b_input ^ pins_s.phase_b_complement;
    assign phase_a   = pins_s.phase_a_input;
    assign phase_b   = pins_s.phase_b_input;

    logic       pair_ok;
    logic       quad_mode;
    assign quad_mode = (mode == QED_MODE_QUAD_SE) || (mode == QED_MODE_QUAD_DIFF);
    assign pair_ok   = (mode != QED_MODE_QUAD_DIFF) || (diff_a_ok && diff_b_ok);

    ////////////////////////////////////////////////////////////////////////////
    // quadrature state tracking
    logic [1:0] state_q;
    logic [1:0] state_now;
    logic       step_up;
    logic       step_down;
    logic       illegal;

    assign state_now = {phase_a, phase_b};

    // gray sequence 00 -> 10 -> 11 -> 01 counts up, reverse counts down
    always_comb begin
        step_up   = 1'b0;
        step_down = 1'b0;
        illegal   = 1'b0;
        case ({state_q, state_now})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: step_up   = 1'b1;
            4'b0001, 4'b0111, 4'b1110, 4'b1000: step_down = 1'b1;
            4'b0011, 4'b1100, 4'b0110, 4'b1001: illegal   = 1'b1;
            default: ;
        endcase
    end

    // a bad pair holds the last state so no false edge is taken
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= 2'h0;
        end else if (pair_ok) begin
            state_q <= state_now;
        end
    end

    // one clock period is well under the 83 ns spacing of counts at the top rate,
    // so every legal state change is seen once
    logic quad_inc;
    logic quad_dec;
    assign quad_inc = quad_mode && pair_ok && step_up;
    assign quad_dec = quad_mode && pair_ok && step_down;

    // sticky until reset; tells software the input outran the sampler
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            quad_error <= 1'b0;
        end else if (quad_mode && pair_ok && illegal) begin
            quad_error <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pulse and direction input
    logic pulse_q;
    logic pulse_rise;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= pins_s.pulse_input;
        end
    end

    assign pulse_rise = (mode == QED_MODE_PULSE_DIR) && pins_s.pulse_input && !pulse_q;

    ////////////////////////////////////////////////////////////////////////////
    // stepper output, open loop
    typedef enum logic [1:0] {
        QED_ST_IDLE = 2'b00,
        QED_ST_HIGH = 2'b01,
        QED_ST_LOW  = 2'b11
    } qed_step_state_t;

    qed_step_state_t step_state_q;
    logic [1:0]      step_cnt_q;
    logic            step_go;

    assign step_go   = (mode == QED_MODE_STEPPER) && step_request && (step_state_q == QED_ST_IDLE);
    assign step_busy = (step_state_q != QED_ST_IDLE);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            step_state_q <= QED_ST_IDLE;
            step_cnt_q   <= QED_STEP_CNT_RESET;
            step_cmd     <= '0;
        end else begin
            case (step_state_q)
                QED_ST_IDLE: begin
                    if (step_go) begin
                        step_cmd.dir_out <= step_dir;
                        step_state_q     <= QED_ST_HIGH;
                        step_cnt_q       <= QED_STEP_CNT_RESET;
                    end
                end
                QED_ST_HIGH: begin
                    // direction is set a cycle ahead of the rising step edge
                    step_cmd.step_out <= 1'b1;
                    step_cnt_q        <= step_cnt_q + 2'h1;
                    if (step_cnt_q == 2'(QED_STEP_HIGH_CYC - 1)) begin
                        step_state_q <= QED_ST_LOW;
                        step_cnt_q   <= QED_STEP_CNT_RESET;
                    end
                end
                QED_ST_LOW: begin
                    step_cmd.step_out <= 1'b0;
                    step_cnt_q        <= step_cnt_q + 2'h1;
                    if (step_cnt_q == 2'(QED_STEP_HIGH_CYC - 1)) begin
                        step_state_q <= QED_ST_IDLE;
                    end
                end
                default: begin
                    step_state_q <= QED_ST_IDLE;
                end
            endcase
        end
    end

    logic step_taken;
    assign step_taken = step_go;

    ////////////////////////////////////////////////////////////////////////////
    // position counter
    logic count_up;
    logic count_down;

    always_comb begin
        count_up   = 1'b0;
        count_down = 1'b0;
        case (mode)
            QED_MODE_QUAD_SE, QED_MODE_QUAD_DIFF: begin
                count_up   = quad_inc;
                count_down = quad_dec;
            end
            QED_MODE_PULSE_DIR: begin
                count_up   = pulse_rise && !pins_s.dir_input;
                count_down = pulse_rise && pins_s.dir_input;
            end
            QED_MODE_STEPPER: begin
                // position follows the commanded steps, no feedback needed
                count_up   = step_taken && !step_dir;
                count_down = step_taken && step_dir;
            end
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // index reference
    logic index_q;
    logic index_rise;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            index_q <= 1'b0;
        end else begin
            index_q <= pins_s.index_input;
        end
    end

    assign index_rise = index_enable && quad_mode && pins_s.index_input && !index_q;

    // the index edge zeroes the count so position is referenced to the mark
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            position <= QED_POS_RESET;
        end else if (index_rise) begin
            position <= QED_POS_RESET;
        end else if (count_up) begin
            position <= position + 32'h0000_0001;
        end else if (count_down) begin
            position <= position - 32'h0000_0001;
        end
    end

    // latch of the count just before the reference; set wins over clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            index_position <= QED_POS_RESET;
            index_seen     <= 1'b0;
        end else if (index_rise) begin
            index_position <= position;
            index_seen     <= 1'b1;
        end else if (index_clear) begin
            index_seen <= 1'b0;
        end
    end

endmodule

// file: design/qed_pkg.sv
// package for the quadrature encoder decoder: modes, timing and carrier structs
package qed_pkg;

    // input decode modes
    typedef enum logic [1:0] {
        QED_MODE_QUAD_SE   = 2'h0,
        QED_MODE_QUAD_DIFF = 2'h1,
        QED_MODE_PULSE_DIR = 2'h2,
        QED_MODE_STEPPER   = 2'h3
    } qed_mode_t;

    localparam int unsigned QED_POS_W          = 32;
    localparam logic [31:0] QED_POS_RESET      = 32'h0000_0000;
    localparam int unsigned QED_MAX_CYCLE_HZ   = 3000000;
    localparam int unsigned QED_MAX_COUNT_HZ   = 12000000;
    localparam int unsigned QED_CLK_HZ         = 25000000;
    // least clock cycles between two quadrature counts at the top rate
    localparam int unsigned QED_MIN_COUNT_CYC  = QED_CLK_HZ / QED_MAX_COUNT_HZ;
    // step pulse high time in clock cycles
    localparam int unsigned QED_STEP_HIGH_CYC  = 2;
    localparam logic [1:0]  QED_STEP_CNT_RESET = 2'h0;

    // encoder pins as they arrive
    typedef struct packed {
        logic phase_a_input;
        logic phase_a_complement;
        logic phase_b_input;
        logic phase_b_complement;
        logic index_input;
        logic pulse_input;
        logic dir_input;
    } qed_enc_pins_t;

    // step command towards the amplifier
    typedef struct packed {
        logic step_out;
        logic dir_out;
    } qed_step_t;

endpackage

// file: design/qed_sync.sv
// two flip-flop synchroniser, one per input bit
`timescale 1ns/10ps
module qed_sync #(
    parameter int unsigned WIDTH = 7
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // the first stage feeds only the second one
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    meta_q[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_q[i]   <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule

// file: verif/qed_decoder_asserts.sv
// port checker for the quadrature decoder
`timescale 1ns/10ps
module qed_decoder_asserts (
    // clock, reset and controls
    input logic                   core_clk,
    input logic                   reset,
    input qed_pkg::qed_mode_t     mode,
    input logic                   index_enable,
    input logic                   index_clear,
    input qed_pkg::qed_enc_pins_t enc_pins,
    input logic                   step_request,
    input logic                   step_dir,
    // decoder results
    input logic [31:0]            position,
    input logic [31:0]            index_position,
    input logic                   index_seen,
    input logic                   quad_error,
    input qed_pkg::qed_step_t     step_cmd,
    input logic                   step_busy
);
    import qed_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic        take;
    logic [31:0] inc;
    assign take = mode == QED_MODE_STEPPER && step_request && !step_busy;
    assign inc  = step_dir ? 32'hFFFF_FFFF : 32'h0000_0001;
    ////////////////////////////////////////////////////////////////
    step_take_a:
    assert property (take |=> step_busy && step_cmd.dir_out == $past(step_dir))
        else $error("step start");
    step_pos_a:
    assert property (take |=> position == $past(position) + $past(inc))
        else $error("step count");
    step_pulse_a:
    assert property ($rose(step_cmd.step_out) |-> ##1 step_cmd.step_out ##1 !step_cmd.step_out)
        else $error("step width");
    busy_span_a:
    assert property ($rose(step_busy) |-> step_busy[*4] ##1 !step_busy)
        else $error("busy span");
    error_hold_a:
    assert property (quad_error |=> quad_error)
        else $error("error lost");
    seen_hold_a:
    assert property (index_seen && !index_clear |=> index_seen)
        else $error("seen lost");
    index_zero_a:
    assert property ($rose(index_seen) |-> position == 32'h0)
        else $error("index zero");
    // outside index use the count only ever moves by one
    count_unit_a:
    assert property (!index_enable && !$past(index_enable) && $changed(position)
        |-> (position - $past(position)) inside {32'h1, 32'hFFFF_FFFF})
        else $error("count jump");
    cover property (take);
    cover property ($rose(index_seen));
    cover property ($rose(quad_error));
endmodule

// file: verif/qed_decoder_test.sv
// self-checking bench for the quadrature decoder
`timescale 1ns/10ps
module qed_decoder_test;
    import qed_pkg::*;
    logic          core_clk, reset, index_enable, index_clear, step_request, step_dir;
    logic          index_seen, quad_error, step_busy;
    logic [31:0]   position, index_position, exp_pos;
    qed_mode_t     mode;
    qed_enc_pins_t enc_pins;
    qed_step_t     step_cmd;
    int            err_total, checked;
    qed_decoder dut (
        .core_clk(core_clk), .reset(reset), .mode(mode), .index_enable(index_enable),
        .index_clear(index_clear), .enc_pins(enc_pins), .step_request(step_request),
        .step_dir(step_dir), .position(position), .index_position(index_position),
        .index_seen(index_seen), .quad_error(quad_error), .step_cmd(step_cmd),
        .step_busy(step_busy));
    qed_encoder_model enc (.core_clk(core_clk), .pins(enc_pins));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic end_sim();
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_quad(input qed_mode_t m);
        mode <= m;
        enc.quad(8, 1'b1);
        exp_pos = exp_pos + 32'h8;
        chk("up", position, exp_pos);
        enc.quad(3, 1'b0);
        exp_pos = exp_pos - 32'h3;
        chk("down", position, exp_pos);
    endtask
    task automatic t_pair();
        mode <= QED_MODE_QUAD_DIFF;
        enc.split(1'b1);
        chk("pair bad", position, exp_pos);
        chk("pair flag", {31'h0, quad_error}, 32'h0);
        enc.split(1'b0);
        chk("pair back", position, exp_pos);
    endtask
    task automatic t_index();
        mode <= QED_MODE_QUAD_SE;
        index_enable <= 1'b1;
        enc.quad(5, 1'b1);
        enc.mark();
        chk("capture", index_position, exp_pos + 32'h5);
        chk("zero", position, 32'h0);
        chk("seen", {31'h0, index_seen}, 32'h1);
        exp_pos = 32'h0;
        index_enable <= 1'b0;
        index_clear <= 1'b1;
        @(posedge core_clk);
        index_clear <= 1'b0;
        enc.mark();
        chk("off", position, exp_pos);
        chk("clear", {31'h0, index_seen}, 32'h0);
    endtask
    task automatic t_pulse();
        mode <= QED_MODE_PULSE_DIR;
        enc.pulse(3, 1'b0);
        enc.pulse(2, 1'b1);
        exp_pos = exp_pos + 32'h1;
        chk("pulse", position, exp_pos);
    endtask
    task automatic t_step(input logic d);
        mode <= QED_MODE_STEPPER;
        @(posedge core_clk);
        step_request <= 1'b1;
        step_dir <= d;
        @(posedge core_clk);
        step_request <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("step high", {31'h0, step_cmd.step_out}, 32'h1);
        // a request in mid-pulse must be dropped
        step_request <= 1'b1;
        @(posedge core_clk);
        step_request <= 1'b0;
        for (int i = 0; i < 10 && step_busy !== 1'b0; i++) @(posedge core_clk);
        chk("busy", {31'h0, step_busy}, 32'h0);
        chk("step low", {31'h0, step_cmd.step_out}, 32'h0);
        exp_pos = d ? exp_pos - 32'h1 : exp_pos + 32'h1;
        chk("step", position, exp_pos);
        chk("dir", {31'h0, step_cmd.dir_out}, {31'h0, d});
    endtask
    task automatic t_illegal();
        mode <= QED_MODE_QUAD_SE;
        @(posedge core_clk);
        enc.jump();
        chk("hold", position, exp_pos);
        chk("flag", {31'h0, quad_error}, 32'h1);
        enc.quad(1, 1'b1);
        exp_pos = exp_pos + 32'h1;
        chk("after", position, exp_pos);
        chk("sticky", {31'h0, quad_error}, 32'h1);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        {reset, index_enable, index_clear, step_request, step_dir} = 5'h10;
        mode = QED_MODE_QUAD_SE;
        exp_pos = 32'h0;
        err_total = 0;
        checked = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_quad(QED_MODE_QUAD_SE);
        t_quad(QED_MODE_QUAD_DIFF);
        t_pair();
        t_index();
        t_pulse();
        t_step(1'b0);
        t_step(1'b1);
        t_illegal();
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        end_sim();
    end
endmodule
bind qed_decoder qed_decoder_asserts u_chk (
    .core_clk(core_clk), .reset(reset), .mode(mode), .index_enable(index_enable),
    .index_clear(index_clear), .enc_pins(enc_pins), .step_request(step_request),
    .step_dir(step_dir), .position(position), .index_position(index_position),
    .index_seen(index_seen), .quad_error(quad_error), .step_cmd(step_cmd),
    .step_busy(step_busy));

// file: verif/qed_encoder_model.sv
// behavioural incremental encoder driving the decoder pins
`timescale 1ns/10ps
module qed_encoder_model (
    // pacing clock
    input  logic                   core_clk,
    // encoder pins
    output qed_pkg::qed_enc_pins_t pins
);
    import qed_pkg::*;
    logic [1:0] ab = 2'h0;
    logic       idx = 1'b0, pul = 1'b0, dir = 1'b0, bad = 1'b0;
    // bad makes the a pair halves agree, as a broken differential line would
    assign pins = {ab[1], ~ab[1] ^ bad, ab[0], ~ab[0], idx, pul, dir};
    // four stable clocks per level keeps edges well under the top rate
    task automatic wt();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic quad(input int n, input logic up);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            ab <= up ? {~ab[0], ab[1]} : {ab[0], ~ab[1]};
            wt();
        end
    endtask
    task automatic pulse(input int n, input logic d);
        dir <= d;
        for (int i = 0; i < n; i++) begin
            wt();
            pul <= 1'b1;
            wt();
            pul <= 1'b0;
        end
        wt();
    endtask
    task automatic mark();
        idx <= 1'b1;
        wt();
        idx <= 1'b0;
        wt();
    endtask
    // both phases at once, a fault only when a scenario asks
    task automatic jump();
        ab <= ~ab;
        wt();
    endtask
    // flips phase a while its complement stays, or puts both back
    task automatic split(input logic on);
        ab[1] <= ~ab[1];
        bad   <= on;
        wt();
    endtask
endmodule
